// file: common/diag_log_pkg.sv
package diag_log_pkg;
	// ----------------------------------------
	// store geometry
	// ----------------------------------------
	localparam int STORE_DEPTH = 9;
	localparam int PTR_W = 4;
	localparam logic [3:0] PTR_LAST = 4'h8;
	localparam logic [3:0] PTR_ZERO = 4'h0;
	// ----------------------------------------
	// event identifiers
	// ----------------------------------------
	localparam logic [15:0] EVENT_ID_PREFIX = 16'hF1C8;
	localparam logic [7:0] CLASS_BACKPLANE = 8'h1E;
	localparam logic [7:0] NUM_RESTART_ABORT = 8'h0D;
	localparam logic [7:0] NUM_READ_FAIL = 8'h0E;
	localparam logic [7:0] NUM_WRITE_FAIL = 8'h0F;
	localparam logic [7:0] NUM_BAD_LENGTH = 8'h41;
	// ----------------------------------------
	// transfer length limits
	// ----------------------------------------
	localparam logic [15:0] LEN_MIN = 16'h0001;
	localparam logic [15:0] LEN_MAX = 16'h0400;
	// ----------------------------------------
	// interrupt information records
	// ----------------------------------------
	localparam logic [31:0] REC_WIRE_BREAK = 32'h0002_0C25;
	localparam logic [31:0] REC_PARAM_ERR = 32'h0000_0C83;
	localparam logic [31:0] REC_NONE = 32'h0000_0000;
	// ----------------------------------------
	// entry-select states
	// ----------------------------------------
	typedef enum logic [1:0] {SRC_IDLE, SRC_EXT, SRC_INT} src_e;
endpackage

// file: rtl/diag_event_logger.sv
`timescale 1ns/10ps
// Summary of operation
// - ring store holds at most nine entries
// - full store drops oldest for newest
// - readout gives newest entry first
// - events logged in order they occur
// - store cleared on reset or reparameterize
// - event identifier prefixed with constant value
// - interrupt enable setting, reset disabled
// - interrupt only on wire break, setup error
// - four-byte record offered with interrupt
// - fixed record bytes per interrupt cause
// - interrupt lights fault indicator, data readable
// - bad transfer length rejected and logged
// - record read failure logged, code kept
// - record write failure logged, code kept
// - abandoned request on restart is logged
module diag_event_logger
	import diag_log_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// configuration
	input wire logic reparam_i,
	input wire logic irq_enable_i,
	// interrupt causes
	input wire logic wire_break_i,
	input wire logic param_error_i,
	// host request events
	input wire logic len_check_i,
	input wire logic [15:0] transfer_length_i,
	input wire logic read_fail_i,
	input wire logic write_fail_i,
	input wire logic [15:0] fail_code_i,
	input wire logic restart_abort_i,
	// generic event logging
	input wire logic ev_valid_i,
	input wire logic [7:0] ev_class_i,
	input wire logic [7:0] ev_number_i,
	// host interrupt acknowledge and readout
	input wire logic irq_ack_i,
	input wire logic [3:0] rd_idx_i,
	// outputs
	output logic len_reject_o,
	output logic [31:0] event_id_o,
	output logic [3:0] entry_count_o,
	output logic diag_irq_o,
	output logic [31:0] diag_record_o,
	output logic system_fault_indicator_o,
	output logic [15:0] read_fail_code_o,
	output logic [15:0] write_fail_code_o
);
	logic irq_en_reg;
	logic irq_en_next;
	logic irq_reg;
	logic irq_next;
	logic [31:0] rec_reg;
	logic [31:0] rec_next;
	logic fault_reg;
	logic fault_next;
	logic rej_reg;
	logic rej_next;
	logic [15:0] rdcode_reg;
	logic [15:0] rdcode_next;
	logic [15:0] wrcode_reg;
	logic [15:0] wrcode_next;
	logic [31:0] id_reg;
	logic [31:0] id_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic len_bad;
	logic wr;
	logic clear;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic [3:0] count;

	// --------------------------------------------
	// entry encoding
	// --------------------------------------------
	// backplane-class entries share one class byte
	function automatic logic [15:0] backplane_entry(input logic [7:0] num);
		return {CLASS_BACKPLANE, num};
	endfunction

	// --------------------------------------------
	// event selection, one entry per cycle
	// --------------------------------------------
	assign len_bad = (transfer_length_i < LEN_MIN) || (transfer_length_i > LEN_MAX);
	assign clear = reparam_i;

	always_comb
	begin
		wr = 1'b1;
		if (restart_abort_i)
			wr_data = backplane_entry(NUM_RESTART_ABORT);
		else if (len_check_i && len_bad)
			wr_data = backplane_entry(NUM_BAD_LENGTH);
		else if (read_fail_i)
			wr_data = backplane_entry(NUM_READ_FAIL);
		else if (write_fail_i)
			wr_data = backplane_entry(NUM_WRITE_FAIL);
		else if (ev_valid_i)
			wr_data = {ev_class_i, ev_number_i};
		else
		begin
			wr = 1'b0;
			wr_data = 16'h0000;
		end
	end

	diag_ring_store u_store (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(clear),
		.wr_i(wr),
		.wr_data_i(wr_data),
		.rd_idx_i(rd_idx_i),
		.rd_data_o(rd_data),
		.count_o(count)
	);

	// --------------------------------------------
	// interrupt group: enable, request, record, lamp
	// --------------------------------------------
	// a new cause outranks a same-cycle ack or clear
	always_comb
	begin
		irq_en_next = irq_enable_i;
		irq_next = irq_reg;
		rec_next = rec_reg;
		fault_next = fault_reg;
		if (irq_ack_i)
			irq_next = 1'b0;
		if (clear)
			fault_next = 1'b0;
		if (irq_en_reg && wire_break_i)
		begin
			irq_next = 1'b1;
			rec_next = REC_WIRE_BREAK;
			fault_next = 1'b1;
		end
		else if (irq_en_reg && param_error_i)
		begin
			irq_next = 1'b1;
			rec_next = REC_PARAM_ERR;
			fault_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_en_reg <= 1'b0;
			irq_reg <= 1'b0;
			rec_reg <= REC_NONE;
			fault_reg <= 1'b0;
		end
		else
		begin
			irq_en_reg <= irq_en_next;
			irq_reg <= irq_next;
			rec_reg <= rec_next;
			fault_reg <= fault_next;
		end
	end

	// --------------------------------------------
	// host request group: length reject, fail codes
	// --------------------------------------------
	// a fresh fail code outranks a same-cycle clear
	always_comb
	begin
		rej_next = len_check_i && len_bad;
		rdcode_next = rdcode_reg;
		wrcode_next = wrcode_reg;
		if (clear)
		begin
			rdcode_next = 16'h0000;
			wrcode_next = 16'h0000;
		end
		if (read_fail_i)
			rdcode_next = fail_code_i;
		if (write_fail_i)
			wrcode_next = fail_code_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rej_reg <= 1'b0;
			rdcode_reg <= 16'h0000;
			wrcode_reg <= 16'h0000;
		end
		else
		begin
			rej_reg <= rej_next;
			rdcode_reg <= rdcode_next;
			wrcode_reg <= wrcode_next;
		end
	end

	// --------------------------------------------
	// readout group: event identifier and count
	// --------------------------------------------
	// id follows the store one cycle behind a write
	always_comb
	begin
		id_next = {EVENT_ID_PREFIX, rd_data};
		cnt_next = count;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			id_reg <= 32'h0000_0000;
			cnt_reg <= PTR_ZERO;
		end
		else
		begin
			id_reg <= id_next;
			cnt_reg <= cnt_next;
		end
	end

	// outputs straight from flip-flops
	assign len_reject_o = rej_reg;
	assign event_id_o = id_reg;
	assign entry_count_o = cnt_reg;
	assign diag_irq_o = irq_reg;
	assign diag_record_o = rec_reg;
	assign system_fault_indicator_o = fault_reg;
	assign read_fail_code_o = rdcode_reg;
	assign write_fail_code_o = wrcode_reg;
endmodule // diag_event_logger

// file: rtl/diag_ring_store.sv
`timescale 1ns/10ps
module diag_ring_store
	import diag_log_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// write side
	input wire logic clear_i,
	input wire logic wr_i,
	input wire logic [15:0] wr_data_i,
	// read side, index 0 is newest
	input wire logic [3:0] rd_idx_i,
	output logic [15:0] rd_data_o,
	output logic [3:0] count_o
);
	logic [15:0] mem [STORE_DEPTH];
	logic [3:0] head_reg;
	logic [3:0] head_next;
	logic [3:0] count_reg;
	logic [3:0] count_next;
	logic [4:0] pos;

	// --------------------------------------------
	// pointer and count
	// --------------------------------------------
	always_comb
	begin
		head_next = head_reg;
		count_next = count_reg;
		if (clear_i)
		begin
			head_next = PTR_ZERO;
			count_next = PTR_ZERO;
		end
		else if (wr_i)
		begin
			head_next = (head_reg == PTR_LAST) ? PTR_ZERO : head_reg + 4'h1;
			if (count_reg != PTR_LAST + 4'h1)
				count_next = count_reg + 4'h1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			head_reg <= PTR_ZERO;
			count_reg <= PTR_ZERO;
		end
		else
		begin
			head_reg <= head_next;
			count_reg <= count_next;
		end
	end

	// entry write, overwrites oldest slot when full
	always_ff @(posedge clk_i)
	begin
		if (wr_i && !clear_i)
			mem[head_reg] <= wr_data_i;
	end

	// newest-first readout
	always_comb
	begin
		pos = {1'b0, head_reg} + 5'd8 - {1'b0, rd_idx_i};
		if (pos >= 5'd9)
			pos = pos - 5'd9;
		rd_data_o = (rd_idx_i < count_reg) ? mem[pos[3:0]] : 16'h0000;
	end

	assign count_o = count_reg;
endmodule // diag_ring_store

// file: test/diag_log_props.sv
`timescale 1ns/10ps
module diag_log_props
	import diag_log_pkg::*;
(
	input wire logic clk_i, rst_i, reparam_i, wire_break_i, param_error_i, len_check_i,
	input wire logic read_fail_i, write_fail_i, restart_abort_i, irq_ack_i,
	input wire logic len_reject_o, diag_irq_o, system_fault_indicator_o,
	input wire logic [15:0] transfer_length_i, fail_code_i, read_fail_code_o, write_fail_code_o,
	input wire logic [31:0] event_id_o, diag_record_o,
	input wire logic [3:0] entry_count_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// request shapes
	sequence bad_len;
		len_check_i && (transfer_length_i < LEN_MIN || transfer_length_i > LEN_MAX);
	endsequence
	sequence no_rival;
		!restart_abort_i && !len_check_i && !reparam_i;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	len_bad_a: assert property (bad_len |=> len_reject_o)
		else $error("bad length not rejected");
	len_idle_a: assert property (!len_check_i |=> !len_reject_o)
		else $error("reject without check");
	count_max_a: assert property (entry_count_o <= 4'h9)
		else $error("count above nine");
	irq_cause_a: assert property ($rose(diag_irq_o) |-> $past(wire_break_i) || $past(param_error_i))
		else $error("interrupt without cause");
	rec_value_a: assert property (diag_irq_o |-> diag_record_o == 32'h0002_0C25
		|| diag_record_o == REC_PARAM_ERR) else $error("bad record");
	irq_fault_a: assert property ($rose(diag_irq_o) |-> system_fault_indicator_o)
		else $error("fault lamp off");
	irq_hold_a: assert property (diag_irq_o && !irq_ack_i && !reparam_i |=> diag_irq_o)
		else $error("interrupt dropped");
	rd_code_a: assert property (read_fail_i ##0 no_rival |=> read_fail_code_o == $past(fail_code_i))
		else $error("read code lost");
	wr_code_a: assert property (write_fail_i && !read_fail_i ##0 no_rival |=>
		write_fail_code_o == $past(fail_code_i)) else $error("write code lost");
	store_clear_a: assert property (reparam_i |=> ##[0:1] entry_count_o == 4'h0)
		else $error("store not cleared");
	id_prefix_a: assert property (!$past(rst_i) |-> event_id_o[31:16] == EVENT_ID_PREFIX)
		else $error("bad id prefix");
endmodule // diag_log_props
bind diag_event_logger diag_log_props u_props (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.reparam_i(reparam_i),
	.wire_break_i(wire_break_i),
	.param_error_i(param_error_i),
	.len_check_i(len_check_i),
	.read_fail_i(read_fail_i),
	.write_fail_i(write_fail_i),
	.restart_abort_i(restart_abort_i),
	.irq_ack_i(irq_ack_i),
	.len_reject_o(len_reject_o),
	.diag_irq_o(diag_irq_o),
	.system_fault_indicator_o(system_fault_indicator_o),
	.transfer_length_i(transfer_length_i),
	.fail_code_i(fail_code_i),
	.read_fail_code_o(read_fail_code_o),
	.write_fail_code_o(write_fail_code_o),
	.event_id_o(event_id_o),
	.diag_record_o(diag_record_o),
	.entry_count_o(entry_count_o)
);

// file: test/host_cpu_model.sv
`timescale 1ns/10ps
module host_cpu_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic diag_irq_i,
	input wire logic [7:0] ack_delay_i,
	output logic irq_ack_o
);
	logic [7:0] wait_cnt;
	initial irq_ack_o = 1'b0;
	// host sees the interrupt, then acknowledges after a delay
	always @(negedge clk_i)
	begin
		if (rst_i || !diag_irq_i || irq_ack_o)
		begin
			wait_cnt <= 8'h00;
			irq_ack_o <= 1'b0;
		end
		else if (wait_cnt == ack_delay_i)
			irq_ack_o <= 1'b1;
		else
			wait_cnt <= wait_cnt + 8'h01;
	end
endmodule // host_cpu_model

// file: test/test_diag_event_logger.sv
`timescale 1ns/10ps
module test_diag_event_logger
	import diag_log_pkg::*;
;
	logic clk_i = 0, rst_i = 1, reparam_i = 0, irq_enable_i = 0, wire_break_i = 0;
	logic param_error_i = 0, len_check_i = 0, read_fail_i = 0, write_fail_i = 0;
	logic restart_abort_i = 0, ev_valid_i = 0, irq_ack_i, len_reject_o, diag_irq_o;
	logic system_fault_indicator_o;
	logic [15:0] transfer_length_i = 0, fail_code_i = 0, read_fail_code_o, write_fail_code_o;
	logic [7:0] ev_class_i = 0, ev_number_i = 0, ack_dly = 0;
	logic [3:0] rd_idx_i = 0, entry_count_o;
	logic [31:0] event_id_o, diag_record_o;
	int error_cnt = 0, num_checks = 0;
	diag_event_logger u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.reparam_i(reparam_i),
		.irq_enable_i(irq_enable_i),
		.wire_break_i(wire_break_i),
		.param_error_i(param_error_i),
		.len_check_i(len_check_i),
		.transfer_length_i(transfer_length_i),
		.read_fail_i(read_fail_i),
		.write_fail_i(write_fail_i),
		.fail_code_i(fail_code_i),
		.restart_abort_i(restart_abort_i),
		.ev_valid_i(ev_valid_i),
		.ev_class_i(ev_class_i),
		.ev_number_i(ev_number_i),
		.irq_ack_i(irq_ack_i),
		.rd_idx_i(rd_idx_i),
		.len_reject_o(len_reject_o),
		.event_id_o(event_id_o),
		.entry_count_o(entry_count_o),
		.diag_irq_o(diag_irq_o),
		.diag_record_o(diag_record_o),
		.system_fault_indicator_o(system_fault_indicator_o),
		.read_fail_code_o(read_fail_code_o),
		.write_fail_code_o(write_fail_code_o)
	);
	host_cpu_model u_host (.clk_i, .rst_i, .diag_irq_i(diag_irq_o), .ack_delay_i(ack_dly),
		.irq_ack_o(irq_ack_i));
	always #50 clk_i = ~clk_i;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask
	task id_at(input logic [3:0] i, input logic [7:0] c, input logic [7:0] n);
		rd_idx_i = i;
		tick(2);
		chk(event_id_o, {EVENT_ID_PREFIX, c, n});
	endtask
	task irq_done;
		repeat (20) if (diag_irq_o) tick(1);
		chk(diag_irq_o, 0);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		chk(entry_count_o, 0);
		pulse(wire_break_i);
		pulse(param_error_i);
		tick(1);
		chk(diag_irq_o, 0);
		chk(system_fault_indicator_o, 0);
	endtask
	task t_ring;
		ev_class_i = 8'h10;
		ev_valid_i = 1;
		for (int k = 1; k <= 11; k++)
		begin
			ev_number_i = k[7:0];
			tick(1);
		end
		ev_valid_i = 0;
		tick(1);
		chk(entry_count_o, 9);
		id_at(0, 8'h10, 8'h0B);
		id_at(8, 8'h10, 8'h03);
	endtask
	task t_irq;
		irq_enable_i = 1;
		ack_dly = 8'h08;
		tick(1);
		pulse(wire_break_i);
		chk(diag_irq_o, 1);
		chk(diag_record_o, 32'h0002_0C25);
		chk(system_fault_indicator_o, 1);
		irq_done();
		ack_dly = 8'h00;
		pulse(param_error_i);
		chk(diag_record_o, REC_PARAM_ERR);
		irq_done();
	endtask
	task t_host;
		logic [15:0] lens [4] = '{16'h0000, 16'h0001, 16'h0400, 16'h0401};
		for (int k = 0; k < 4; k++)
		begin
			transfer_length_i = lens[k];
			pulse(len_check_i);
			chk(len_reject_o, k == 0 || k == 3);
		end
		id_at(0, CLASS_BACKPLANE, 8'h41);
		fail_code_i = 16'hbeef;
		pulse(read_fail_i);
		chk(read_fail_code_o, 16'hbeef);
		id_at(0, CLASS_BACKPLANE, 8'h0E);
		fail_code_i = 16'h1234;
		pulse(write_fail_i);
		chk(write_fail_code_o, 16'h1234);
		id_at(0, CLASS_BACKPLANE, 8'h0F);
		pulse(restart_abort_i);
		id_at(0, CLASS_BACKPLANE, 8'h0D);
	endtask
	task t_reparam;
		pulse(reparam_i);
		tick(1);
		chk(entry_count_o, 0);
		chk(system_fault_indicator_o, 0);
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		tick(6);
		rst_i = 0;
		tick(1);
		t_reset();
		t_ring();
		t_irq();
		t_host();
		t_reparam();
		end_sim();
	end
	initial
	begin
		#2000000;
		error_cnt++;
		end_sim();
	end
endmodule // test_diag_event_logger
